/* include/ecc_pkg.sv */
// shared constants, register map and check-code functions for the data ram protection
package ecc_pkg;

    // ==========================================================
    // array geometry
    localparam int DATA_W = 8;
    localparam int CHECK_W = 5;
    localparam int WORD_W = DATA_W + CHECK_W;
    localparam int DEPTH = 2048;
    localparam int INDEX_W = 11;
    localparam int ADDR_W = 16;

    // ==========================================================
    // register map
    localparam logic [15:0] DATA_PROTECT_CONFIG_ADDR = 16'ha02d;
    localparam logic [15:0] DATA_FAULT_ADDR_LOW_ADDR = 16'ha02e;
    localparam logic [15:0] DATA_FAULT_ADDR_HIGH_ADDR = 16'ha02f;

    localparam int PROTECT_ENABLE_BIT = 7;
    localparam int UNCORR_IRQ_ENABLE_BIT = 5;
    localparam int CORR_IRQ_ENABLE_BIT = 4;
    localparam int UNCORR_ERROR_FLAG_BIT = 1;
    localparam int CORR_ERROR_FLAG_BIT = 0;

    localparam logic [7:0] CONFIG_RESET = 8'h80;
    localparam logic [15:0] FAULT_ADDR_RESET = 16'h8000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [CHECK_W-1:0] CHECK_NONE = 5'h00;
    localparam logic [3:0] SYNDROME_MAX_SINGLE = 4'hc;

    // ==========================================================
    // check code: four hamming bits plus one overall parity bit
    function automatic logic [CHECK_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
        logic [3:0] p;
        p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        return {(^d) ^ (^p), p};
    endfunction : ecc_encode

    // syndrome points at the failing hamming position, 0 when clean
    function automatic logic [3:0] ecc_syndrome(input logic [WORD_W-1:0] w);
        logic [CHECK_W-1:0] c;
        c = ecc_encode(w[DATA_W-1:0]);
        return c[3:0] ^ w[WORD_W-2:DATA_W];
    endfunction : ecc_syndrome

    // data bit to flip for a given syndrome; check-bit positions flip nothing
    function automatic logic [DATA_W-1:0] ecc_flip(input logic [3:0] s);
        unique case (s)
            4'h3: return 8'h01;
            4'h5: return 8'h02;
            4'h6: return 8'h04;
            4'h7: return 8'h08;
            4'h9: return 8'h10;
            4'ha: return 8'h20;
            4'hb: return 8'h40;
            4'hc: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction : ecc_flip

endpackage : ecc_pkg

/* include/data_ram_if.sv */
// link between the core end and the protected data ram end
interface data_ram_if;
    // memory access
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic mem_ack;
    // register access
    logic reg_req;
    logic reg_we;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    // interrupt requests
    logic irq_corr;
    logic irq_uncorr;

    modport ram_end (
        input mem_req, mem_we, mem_addr, mem_wdata, reg_req, reg_we, reg_addr, reg_wdata,
        output mem_rdata, mem_ack, reg_rdata, reg_ack, irq_corr, irq_uncorr
    );
    modport core_end (
        output mem_req, mem_we, mem_addr, mem_wdata, reg_req, reg_we, reg_addr, reg_wdata,
        input mem_rdata, mem_ack, reg_rdata, reg_ack, irq_corr, irq_uncorr
    );
endinterface : data_ram_if

/* hw/data_sram_ecc_checker.sv */
// protected data ram: 2048 x 13 array, check encode/decode, flags, fault address
//
// Notes on behaviour
// [RULE1] 2048 words, 8 data plus 5 check
// [RULE2] correct single-bit, detect double-bit errors per byte
// [RULE3] encode and check fully in hardware
// [RULE4] uncorrectable read captures address, raises interrupt
// [RULE5] correctable read returns the corrected byte
// [RULE6] switching protection invalidates memory; reinitialise after
// [RULE7] software initialises memory after reset
// [RULE8] config bit 7 enables protection, reset on
// [RULE9] bit 5 uncorrectable, bit 4 correctable enables
// [RULE10] correctable flag bit 0, uncorrectable bit 1
// [RULE11] flags set regardless of enable, software clears
// [RULE12] software rewrites corrected data after correctable interrupt
// [RULE13] read-only 16-bit fault address, low and high
// [RULE14] fault address frozen while any flag set
// [RULE15] interrupt while flag and enable both set
module data_sram_ecc_checker (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // link to the core end
    data_ram_if.ram_end bus,
    // status for the surrounding chip
    output logic protect_enable_o,
    output logic corr_error_flag_o,
    output logic uncorr_error_flag_o
);

    // ==========================================================
    // state
    typedef struct packed {
        logic protect_enable;
        logic uncorr_irq_enable;
        logic corr_irq_enable;
        logic uncorr_error_flag;
        logic corr_error_flag;
        logic [15:0] fault_address;
        logic [7:0] mem_rdata;
        logic mem_ack;
        logic [7:0] reg_rdata;
        logic reg_ack;
        logic irq_corr;
        logic irq_uncorr;
    } dev_state_t;

    localparam dev_state_t STATE_RESET = '{
        protect_enable: ecc_pkg::CONFIG_RESET[ecc_pkg::PROTECT_ENABLE_BIT],
        uncorr_irq_enable: ecc_pkg::CONFIG_RESET[ecc_pkg::UNCORR_IRQ_ENABLE_BIT],
        corr_irq_enable: ecc_pkg::CONFIG_RESET[ecc_pkg::CORR_IRQ_ENABLE_BIT],
        uncorr_error_flag: ecc_pkg::CONFIG_RESET[ecc_pkg::UNCORR_ERROR_FLAG_BIT],
        corr_error_flag: ecc_pkg::CONFIG_RESET[ecc_pkg::CORR_ERROR_FLAG_BIT],
        fault_address: ecc_pkg::FAULT_ADDR_RESET,
        mem_rdata: ecc_pkg::UNMAPPED_READ,
        mem_ack: 1'b0,
        reg_rdata: ecc_pkg::UNMAPPED_READ,
        reg_ack: 1'b0,
        irq_corr: 1'b0,
        irq_uncorr: 1'b0
    };

    dev_state_t s_r;
    dev_state_t s_nxt;

    // the array is kept apart from the state struct: it has no reset and
    // would otherwise make the struct thousands of bits wide
    logic [ecc_pkg::WORD_W-1:0] mem [ecc_pkg::DEPTH]; // [RULE1]

    // ==========================================================
    // read path decode
    logic [ecc_pkg::INDEX_W-1:0] index;
    logic [ecc_pkg::WORD_W-1:0] raw_word;
    logic [3:0] syndrome;
    logic parity_bad;
    logic rd_access;
    logic corr_event;
    logic uncorr_event;
    logic [7:0] read_byte;
    logic [7:0] config_view;
    logic cfg_write;

    assign index = bus.mem_addr[ecc_pkg::INDEX_W-1:0];
    assign raw_word = mem[index];
    assign syndrome = ecc_pkg::ecc_syndrome(raw_word);
    // overall parity is even over the whole word when no bit has flipped
    assign parity_bad = ^raw_word;
    assign rd_access = bus.mem_req && !bus.mem_we;

    always_comb begin
        corr_event = 1'b0;
        uncorr_event = 1'b0;
        read_byte = raw_word[ecc_pkg::DATA_W-1:0];
        // in unprotected mode check bits are ignored and raw data is returned
        if (rd_access && s_r.protect_enable) begin // [RULE3]
            if (parity_bad && syndrome <= ecc_pkg::SYNDROME_MAX_SINGLE) begin
                corr_event = 1'b1; // [RULE2]
                read_byte = raw_word[ecc_pkg::DATA_W-1:0] ^ ecc_pkg::ecc_flip(syndrome); // [RULE5]
            end else if (parity_bad || syndrome != 4'h0) begin
                // even parity with a syndrome, or a syndrome past the word: two bits
                uncorr_event = 1'b1; // [RULE2]
            end
        end
    end

    assign config_view = {
        s_r.protect_enable, 1'b0, s_r.uncorr_irq_enable, s_r.corr_irq_enable,
        2'b00, s_r.uncorr_error_flag, s_r.corr_error_flag
    };
    assign cfg_write = bus.reg_req && bus.reg_we
        && bus.reg_addr == ecc_pkg::DATA_PROTECT_CONFIG_ADDR;

    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.mem_ack = 1'b0;
        s_nxt.reg_ack = 1'b0;

        // memory answer one cycle after every request, writes included
        if (bus.mem_req) begin
            s_nxt.mem_ack = 1'b1;
            if (!bus.mem_we) begin
                s_nxt.mem_rdata = read_byte; // [RULE5]
            end
        end

        // register write; writing 0 to a flag clears it, writing 1 keeps it
        if (cfg_write) begin
            s_nxt.protect_enable = bus.reg_wdata[ecc_pkg::PROTECT_ENABLE_BIT]; // [RULE8]
            s_nxt.uncorr_irq_enable = bus.reg_wdata[ecc_pkg::UNCORR_IRQ_ENABLE_BIT]; // [RULE9]
            s_nxt.corr_irq_enable = bus.reg_wdata[ecc_pkg::CORR_IRQ_ENABLE_BIT]; // [RULE9]
            s_nxt.uncorr_error_flag = s_r.uncorr_error_flag
                & bus.reg_wdata[ecc_pkg::UNCORR_ERROR_FLAG_BIT]; // [RULE11]
            s_nxt.corr_error_flag = s_r.corr_error_flag
                & bus.reg_wdata[ecc_pkg::CORR_ERROR_FLAG_BIT]; // [RULE11]
        end

        // hardware set comes after the clear so a same-cycle event is kept
        if (corr_event) begin
            s_nxt.corr_error_flag = 1'b1; // [RULE10] [RULE11]
        end
        if (uncorr_event) begin
            s_nxt.uncorr_error_flag = 1'b1; // [RULE4] [RULE10] [RULE11]
        end

        // capture only when no flag was standing before this access
        if ((corr_event || uncorr_event)
            && !(s_r.corr_error_flag || s_r.uncorr_error_flag)) begin // [RULE14]
            s_nxt.fault_address = bus.mem_addr; // [RULE4] [RULE13]
        end

        // register read answer; fault address bytes are read-only
        if (bus.reg_req) begin
            s_nxt.reg_ack = 1'b1;
            if (!bus.reg_we) begin
                unique case (bus.reg_addr)
                    ecc_pkg::DATA_PROTECT_CONFIG_ADDR: s_nxt.reg_rdata = config_view;
                    ecc_pkg::DATA_FAULT_ADDR_LOW_ADDR: s_nxt.reg_rdata = s_r.fault_address[7:0]; // [RULE13]
                    ecc_pkg::DATA_FAULT_ADDR_HIGH_ADDR: s_nxt.reg_rdata = s_r.fault_address[15:8]; // [RULE13]
                    default: s_nxt.reg_rdata = ecc_pkg::UNMAPPED_READ;
                endcase
            end
        end

        s_nxt.irq_corr = s_nxt.corr_error_flag && s_nxt.corr_irq_enable; // [RULE15]
        s_nxt.irq_uncorr = s_nxt.uncorr_error_flag && s_nxt.uncorr_irq_enable; // [RULE4] [RULE15]
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // array write: check bits generated on the fly, zero when unprotected
    always_ff @(posedge clock_i) begin
        if (bus.mem_req && bus.mem_we) begin
            if (s_r.protect_enable) begin
                mem[index] <= {ecc_pkg::ecc_encode(bus.mem_wdata), bus.mem_wdata}; // [RULE1] [RULE3]
            end else begin
                mem[index] <= {ecc_pkg::CHECK_NONE, bus.mem_wdata};
            end
        end
    end

    // ==========================================================
    // outputs
    assign bus.mem_rdata = s_r.mem_rdata;
    assign bus.mem_ack = s_r.mem_ack;
    assign bus.reg_rdata = s_r.reg_rdata;
    assign bus.reg_ack = s_r.reg_ack;
    assign bus.irq_corr = s_r.irq_corr;
    assign bus.irq_uncorr = s_r.irq_uncorr;
    assign protect_enable_o = s_r.protect_enable;
    assign corr_error_flag_o = s_r.corr_error_flag;
    assign uncorr_error_flag_o = s_r.uncorr_error_flag;

endmodule : data_sram_ecc_checker

/* hw/data_ram_core_end.sv */
// core end: initialises the ram, carries user accesses, scrubs corrected words
module data_ram_core_end (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // link to the protected ram
    data_ram_if.core_end bus,
    // user request
    input wire logic user_valid_i,
    input wire logic user_is_reg_i,
    input wire logic user_we_i,
    input wire logic [15:0] user_addr_i,
    input wire logic [7:0] user_wdata_i,
    output logic user_ready_o,
    // user answer
    output logic user_done_o,
    output logic [7:0] user_rdata_o,
    // status
    output logic init_busy_o,
    output logic corr_irq_o,
    output logic uncorr_irq_o
);

    // ==========================================================
    // state
    typedef enum logic [7:0] {
        ST_INIT = 8'h01,
        ST_IDLE = 8'h02,
        ST_USER = 8'h04,
        ST_ADR_LO = 8'h08,
        ST_ADR_HI = 8'h10,
        ST_SCR_RD = 8'h20,
        ST_SCR_WR = 8'h40,
        ST_SCR_CLR = 8'h80
    } core_fsm_t;

    typedef struct packed {
        core_fsm_t fsm;
        logic issued;
        logic [ecc_pkg::INDEX_W-1:0] init_idx;
        logic [7:0] cfg_shadow;
        logic [15:0] fault;
        logic [7:0] scrub_data;
        logic op_is_reg;
        logic op_we;
        logic [15:0] op_addr;
        logic [7:0] op_wdata;
        logic mem_req;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic reg_req;
        logic reg_we;
        logic [15:0] reg_addr;
        logic [7:0] reg_wdata;
        logic user_ready;
        logic user_done;
        logic [7:0] user_rdata;
        logic corr_irq;
        logic uncorr_irq;
    } core_state_t;

    localparam logic [ecc_pkg::INDEX_W-1:0] LAST_IDX = ecc_pkg::INDEX_W'(ecc_pkg::DEPTH - 1);

    core_state_t s_r;
    core_state_t s_nxt;
    logic ack;

    assign ack = bus.mem_ack || bus.reg_ack;

    // ==========================================================
    // next state: every step issues one request pulse, then waits for its ack
    always_comb begin
        s_nxt = s_r;
        s_nxt.mem_req = 1'b0;
        s_nxt.reg_req = 1'b0;
        s_nxt.user_done = 1'b0;
        s_nxt.corr_irq = bus.irq_corr;
        s_nxt.uncorr_irq = bus.irq_uncorr;
        unique case (s_r.fsm)
            ST_INIT: begin
                // zero every word so stale check bits raise no errors
                if (!s_r.issued) begin
                    s_nxt.issued = 1'b1;
                    s_nxt.mem_req = 1'b1; // [RULE7] [RULE6]
                    s_nxt.mem_we = 1'b1;
                    s_nxt.mem_addr = 16'(s_r.init_idx);
                    s_nxt.mem_wdata = 8'h00;
                end else if (ack) begin
                    s_nxt.issued = 1'b0;
                    s_nxt.init_idx = s_r.init_idx + 1'b1;
                    if (s_r.init_idx == LAST_IDX) begin
                        s_nxt.fsm = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (user_valid_i && s_r.user_ready) begin
                    s_nxt.op_is_reg = user_is_reg_i;
                    s_nxt.op_we = user_we_i;
                    s_nxt.op_addr = user_addr_i;
                    s_nxt.op_wdata = user_wdata_i;
                    s_nxt.fsm = ST_USER;
                end else if (bus.irq_corr) begin
                    s_nxt.fsm = ST_ADR_LO; // [RULE12]
                end
            end
            ST_USER: begin
                if (!s_r.issued) begin
                    s_nxt.issued = 1'b1;
                    s_nxt.mem_req = !s_r.op_is_reg;
                    s_nxt.mem_we = s_r.op_we;
                    s_nxt.mem_addr = s_r.op_addr;
                    s_nxt.mem_wdata = s_r.op_wdata;
                    s_nxt.reg_req = s_r.op_is_reg;
                    s_nxt.reg_we = s_r.op_we;
                    s_nxt.reg_addr = s_r.op_addr;
                    s_nxt.reg_wdata = s_r.op_wdata;
                end else if (ack) begin
                    s_nxt.issued = 1'b0;
                    s_nxt.user_done = 1'b1;
                    s_nxt.user_rdata = s_r.op_is_reg ? bus.reg_rdata : bus.mem_rdata;
                    s_nxt.fsm = ST_IDLE;
                    if (s_r.op_is_reg && s_r.op_we
                        && s_r.op_addr == ecc_pkg::DATA_PROTECT_CONFIG_ADDR) begin
                        s_nxt.cfg_shadow = s_r.op_wdata;
                        // a change of protection mode leaves every word garbage
                        if (s_r.op_wdata[ecc_pkg::PROTECT_ENABLE_BIT]
                            != s_r.cfg_shadow[ecc_pkg::PROTECT_ENABLE_BIT]) begin
                            s_nxt.init_idx = '0;
                            s_nxt.fsm = ST_INIT; // [RULE6]
                        end
                    end
                end
            end
            ST_ADR_LO, ST_ADR_HI: begin
                if (!s_r.issued) begin
                    s_nxt.issued = 1'b1;
                    s_nxt.reg_req = 1'b1;
                    s_nxt.reg_we = 1'b0;
                    s_nxt.reg_addr = (s_r.fsm == ST_ADR_LO) ? ecc_pkg::DATA_FAULT_ADDR_LOW_ADDR
                        : ecc_pkg::DATA_FAULT_ADDR_HIGH_ADDR;
                end else if (ack) begin
                    s_nxt.issued = 1'b0;
                    if (s_r.fsm == ST_ADR_LO) begin
                        s_nxt.fault[7:0] = bus.reg_rdata;
                        s_nxt.fsm = ST_ADR_HI;
                    end else begin
                        s_nxt.fault[15:8] = bus.reg_rdata;
                        s_nxt.fsm = ST_SCR_RD;
                    end
                end
            end
            ST_SCR_RD, ST_SCR_WR: begin
                // the read hands back the corrected byte, the write stores it clean
                if (!s_r.issued) begin
                    s_nxt.issued = 1'b1;
                    s_nxt.mem_req = 1'b1;
                    s_nxt.mem_we = (s_r.fsm == ST_SCR_WR);
                    s_nxt.mem_addr = s_r.fault;
                    s_nxt.mem_wdata = s_r.scrub_data; // [RULE12]
                end else if (ack) begin
                    s_nxt.issued = 1'b0;
                    if (s_r.fsm == ST_SCR_RD) begin
                        s_nxt.scrub_data = bus.mem_rdata;
                        s_nxt.fsm = ST_SCR_WR;
                    end else begin
                        s_nxt.fsm = ST_SCR_CLR;
                    end
                end
            end
            ST_SCR_CLR: begin
                // clear only the correctable flag; the uncorrectable one is left alone
                if (!s_r.issued) begin
                    s_nxt.issued = 1'b1;
                    s_nxt.reg_req = 1'b1;
                    s_nxt.reg_we = 1'b1;
                    s_nxt.reg_addr = ecc_pkg::DATA_PROTECT_CONFIG_ADDR;
                    s_nxt.reg_wdata = s_r.cfg_shadow;
                    s_nxt.reg_wdata[ecc_pkg::UNCORR_ERROR_FLAG_BIT] = 1'b1;
                    s_nxt.reg_wdata[ecc_pkg::CORR_ERROR_FLAG_BIT] = 1'b0; // [RULE11]
                end else if (ack) begin
                    s_nxt.issued = 1'b0;
                    s_nxt.fsm = ST_IDLE;
                end
            end
        endcase
        s_nxt.user_ready = (s_nxt.fsm == ST_IDLE) && !(s_nxt.fsm == s_r.fsm && user_valid_i
            && s_r.user_ready) && !bus.irq_corr;
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{fsm: ST_INIT, cfg_shadow: ecc_pkg::CONFIG_RESET, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign bus.mem_req = s_r.mem_req;
    assign bus.mem_we = s_r.mem_we;
    assign bus.mem_addr = s_r.mem_addr;
    assign bus.mem_wdata = s_r.mem_wdata;
    assign bus.reg_req = s_r.reg_req;
    assign bus.reg_we = s_r.reg_we;
    assign bus.reg_addr = s_r.reg_addr;
    assign bus.reg_wdata = s_r.reg_wdata;
    assign user_ready_o = s_r.user_ready;
    assign user_done_o = s_r.user_done;
    assign user_rdata_o = s_r.user_rdata;
    assign init_busy_o = (s_r.fsm == ST_INIT);
    assign corr_irq_o = s_r.corr_irq;
    assign uncorr_irq_o = s_r.uncorr_irq;

endmodule : data_ram_core_end

/* verification/data_ram_link_checker.sv */
// concurrent checks on the link between the core end and the protected data ram
module data_ram_link_checker (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // link signals
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic irq_corr,
    input wire logic irq_uncorr
);
    // ==========================================================
    // properties
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    wire cfg_wr = reg_req && reg_we && reg_addr == ecc_pkg::DATA_PROTECT_CONFIG_ADDR;
    wire mapped = reg_addr inside {[ecc_pkg::DATA_PROTECT_CONFIG_ADDR:16'ha02f]};

    property p_mem_ack;
        mem_req |=> mem_ack;
    endproperty
    a_mem_ack: assert property (p_mem_ack) else $error("memory access not acked");
    property p_mem_quiet;
        !mem_req |=> !mem_ack;
    endproperty
    a_mem_quiet: assert property (p_mem_quiet) else $error("stray memory ack");
    property p_reg_ack;
        reg_req |=> reg_ack;
    endproperty
    a_reg_ack: assert property (p_reg_ack) else $error("register access not acked");
    property p_reg_quiet;
        !reg_req |=> !reg_ack;
    endproperty
    a_reg_quiet: assert property (p_reg_quiet) else $error("stray register ack");
    property p_corr_off;
        cfg_wr && !reg_wdata[4] |=> !irq_corr;
    endproperty
    a_corr_off: assert property (p_corr_off) else $error("corr irq while disabled");
    property p_uncorr_off;
        cfg_wr && !reg_wdata[5] |=> !irq_uncorr;
    endproperty
    a_uncorr_off: assert property (p_uncorr_off) else $error("uncorr irq while disabled");
    property p_rdata_hold;
        !(mem_req && !mem_we) |=> $stable(mem_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_unmapped;
        reg_req && !reg_we && !mapped |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : data_ram_link_checker

/* verification/data_sram_ecc_checker_tb.sv */
// self-checking bench: core end against ram end, plus a ram end driven directly
module data_sram_ecc_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] CFG = ecc_pkg::DATA_PROTECT_CONFIG_ADDR;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic valid = 1'b0, is_reg = 1'b0, we = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic ready, done, busy, cirq, uirq, pe, cf, uf, pe_b, cf_b, uf_b;
    logic [7:0] rdata, got;
    int err_total = 0, checks = 0;
    data_ram_if link ();
    data_ram_if link_b ();

    data_ram_core_end data_ram_core_end_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .bus(link), .user_valid_i(valid), .user_is_reg_i(is_reg), .user_we_i(we),
        .user_addr_i(addr), .user_wdata_i(wdata), .user_ready_o(ready), .user_done_o(done),
        .user_rdata_o(rdata), .init_busy_o(busy), .corr_irq_o(cirq), .uncorr_irq_o(uirq));
    data_sram_ecc_checker data_sram_ecc_checker_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .bus(link), .protect_enable_o(pe), .corr_error_flag_o(cf), .uncorr_error_flag_o(uf));
    // second ram end lets the bench store raw bytes and so plant bit errors
    data_sram_ecc_checker data_sram_ecc_checker_b_inst (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .bus(link_b), .protect_enable_o(pe_b),
        .corr_error_flag_o(cf_b), .uncorr_error_flag_o(uf_b));
    data_ram_link_checker data_ram_link_checker_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .mem_req(link.mem_req), .mem_we(link.mem_we), .mem_rdata(link.mem_rdata),
        .mem_ack(link.mem_ack), .reg_req(link.reg_req), .reg_we(link.reg_we),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .reg_ack(link.reg_ack), .irq_corr(link.irq_corr), .irq_uncorr(link.irq_uncorr));

    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    task automatic uop(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
        int n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (ready !== 1'b1 && n < 8000);
        {valid, is_reg, we, addr, wdata} = {1'b1, r, w, a, d};
        @(posedge clock_i);
        #1;
        valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk("user done", 1'b1, done);
        got = rdata;
    endtask : uop

    task automatic bop(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        if (r) begin
            {link_b.reg_req, link_b.reg_we, link_b.reg_addr, link_b.reg_wdata} = {1'b1, w, a, d};
        end else begin
            {link_b.mem_req, link_b.mem_we, link_b.mem_addr, link_b.mem_wdata} = {1'b1, w, a, d};
        end
        @(posedge clock_i);
        #1;
        chk("ack", 1'b1, r ? link_b.reg_ack : link_b.mem_ack);
        got = r ? link_b.reg_rdata : link_b.mem_rdata;
        {link_b.reg_req, link_b.mem_req} = 2'b00;
    endtask : bop

    task automatic fault_is(input logic [15:0] exp);
        logic [7:0] lo;
        bop(1'b1, 1'b0, ecc_pkg::DATA_FAULT_ADDR_LOW_ADDR, 8'h00);
        lo = got;
        bop(1'b1, 1'b0, ecc_pkg::DATA_FAULT_ADDR_HIGH_ADDR, 8'h00);
        chk("fault address", exp, {got, lo});
    endtask : fault_is

    // ==========================================================
    // sequence
    initial forever #4 clock_i = ~clock_i;

    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        give_verdict();
    end

    initial begin
        {link_b.mem_req, link_b.mem_we, link_b.reg_req, link_b.reg_we} = 4'h0;
        {link_b.mem_addr, link_b.mem_wdata, link_b.reg_addr, link_b.reg_wdata} = 48'h0;
        repeat (20) @(posedge clock_i);
        #1;
        reset_n_i = 1'b1;
        bop(1'b1, 1'b0, CFG, 8'h00);
        chk("config", 8'h80, got);
        chk("protect", 1'b1, pe_b);
        fault_is(16'h8000);
        // with protection off the check bits are stored as zero
        bop(1'b1, 1'b1, CFG, 8'h00);
        bop(1'b0, 1'b1, 16'h0010, 8'h01);
        bop(1'b0, 1'b1, 16'h0030, 8'h01);
        bop(1'b0, 1'b1, 16'h0020, 8'h03);
        bop(1'b1, 1'b1, CFG, 8'hb0);
        bop(1'b0, 1'b1, 16'h0040, 8'ha5);
        bop(1'b0, 1'b0, 16'h0040, 8'h00);
        chk("clean read", 8'ha5, got);
        chk("corr flag", 1'b0, cf_b);
        bop(1'b0, 1'b0, 16'h0010, 8'h00);
        chk("corrected", 8'h00, got);
        chk("corr flag", 1'b1, cf_b);
        chk("corr irq", 1'b1, link_b.irq_corr);
        fault_is(16'h0010);
        bop(1'b0, 1'b0, 16'h0030, 8'h00);
        bop(1'b0, 1'b0, 16'h0020, 8'h00);
        chk("raw", 8'h03, got);
        chk("uncorr irq", 1'b1, link_b.irq_uncorr);
        fault_is(16'h0010);
        bop(1'b1, 1'b1, ecc_pkg::DATA_FAULT_ADDR_LOW_ADDR, 8'hff);
        fault_is(16'h0010);
        bop(1'b1, 1'b0, CFG, 8'h00);
        chk("config", 8'hb3, got);
        bop(1'b1, 1'b1, CFG, 8'h81);
        chk("uncorr flag", 1'b0, uf_b);
        chk("corr irq", 1'b0, link_b.irq_corr);
        bop(1'b1, 1'b1, CFG, 8'h80);
        bop(1'b0, 1'b0, 16'h0020, 8'h00);
        chk("uncorr flag", 1'b1, uf_b);
        chk("uncorr irq", 1'b0, link_b.irq_uncorr);
        fault_is(16'h0020);
        // paired ends: the first request waits out the zero sweep
        uop(1'b1, 1'b0, CFG, 8'h00);
        chk("config", 8'h80, got);
        uop(1'b0, 1'b0, 16'h07ff, 8'h00);
        chk("swept word", 8'h00, got);
        uop(1'b1, 1'b0, 16'ha0ff, 8'h00);
        chk("unmapped", 8'h00, got);
        uop(1'b0, 1'b1, 16'h0805, 8'h3c);
        uop(1'b0, 1'b0, 16'h0005, 8'h00);
        chk("wrapped word", 8'h3c, got);
        uop(1'b1, 1'b1, CFG, 8'hb0);
        uop(1'b1, 1'b0, CFG, 8'h00);
        chk("config", 8'hb0, got);
        chk("core irqs", 2'b00, {cirq, uirq});
        uop(1'b1, 1'b1, CFG, 8'h00);
        chk("busy protect flags", 4'h8, {busy, pe, cf, uf});
        give_verdict();
    end
endmodule : data_sram_ecc_checker_tb
